// ---- hdl/scc_device.sv ----
// device end: three clock control registers, position status readback,
// and the sysref path that they steer
// assumes sysref_in and lsb_in come from outside mclk: both synchronised
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module scc_device
    import scc_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    scc_if.device                  bus,
    input  wire logic              sysref_in,
    input  wire logic              lsb_marker_enable,
    input  wire logic              ddc_bypassed,
    input  wire logic              sample_lsb_in,
    output logic                   sysref_receiver_enable,
    output logic                   sysref_processor_enable,
    output logic                   window_zoom,
    output logic [SEL_W-1:0]       capture_delay_select,
    output logic                   device_clock_dc_mode,
    output logic                   sysref_dc_mode,
    output logic                   feedback_gain_high,
    output logic                   supply_noise_suppress,
    output logic [DEL_W-1:0]       sample_clock_delay,
    output logic                   sysref_event,
    output logic                   sample_lsb_out
);
    logic [7:0]       enable_window;
    logic [7:0]       path_options;
    logic [7:0]       clock_tuning;
    logic [POS_W-1:0] edge_position_status;
    logic [1:0]       sref_sync;
    logic [1:0]       lsb_sync;
    logic             sref_prev;
    logic             sref_aligned;
    logic [SEL_W:0]   delay_cnt;
    logic             edge_pending;
    logic [7:0]       next_rdata;
    logic             wr_enable_window;
    logic             wr_path_options;
    logic             wr_clock_tuning;
    logic             sref_rise;
    logic             stamp_active;

    // reserved bits are masked on write and read back as zero
    assign wr_enable_window = bus.wr && (bus.addr == OFS_ENABLE_WINDOW);
    assign wr_path_options  = bus.wr && (bus.addr == OFS_PATH_OPTIONS);
    assign wr_clock_tuning  = bus.wr && (bus.addr == OFS_CLOCK_TUNING);

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            enable_window <= RST_ENABLE_WINDOW;
        else if (wr_enable_window)
            enable_window <= bus.wdata & MASK_ENABLE_WINDOW;
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            path_options <= RST_PATH_OPTIONS;
        else if (wr_path_options)
            path_options <= bus.wdata & MASK_PATH_OPTIONS;
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            clock_tuning <= RST_CLOCK_TUNING;
        else if (wr_clock_tuning)
            clock_tuning <= bus.wdata & MASK_CLOCK_TUNING;
    end

    assign sysref_receiver_enable  = enable_window[BIT_RECV_EN];
    assign sysref_processor_enable = enable_window[BIT_PROC_EN];
    assign window_zoom             = enable_window[BIT_ZOOM];
    assign capture_delay_select    = enable_window[SEL_MSB -: SEL_W];
    assign device_clock_dc_mode    = path_options[BIT_DEV_DC];
    assign sysref_dc_mode          = path_options[BIT_SYS_DC];
    assign feedback_gain_high      = clock_tuning[BIT_FB_GAIN];
    assign supply_noise_suppress   = clock_tuning[BIT_NOISE_SUPP];
    assign sample_clock_delay      = clock_tuning[DEL_MSB -: DEL_W];

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            sref_sync <= 2'h0;
            lsb_sync  <= 2'h0;
        end
        else
        begin
            sref_sync <= {sref_sync[0], sysref_in};
            lsb_sync  <= {lsb_sync[0], sample_lsb_in};
        end
    end

    // receiver off means the pin is never looked at
    assign sref_aligned = sysref_receiver_enable
                        & (sref_sync[1] ^ path_options[BIT_INVERT]);

    // edge taken after inversion, so either polarity aligns on a rising edge
    assign sref_rise = sref_aligned && !sref_prev;

    // position status: shift in aligned level; zoom samples every
    // cycle, otherwise every cycle except the one where the aligned level falls
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            edge_position_status <= {POS_W{1'b0}};
            sref_prev            <= 1'b0;
        end
        else
        begin
            sref_prev <= sref_aligned;
            if (window_zoom || !sref_prev || sref_aligned)
                edge_position_status <= {edge_position_status[POS_W-2:0],
                                         sref_aligned};
        end
    end

    // event fires after the selected delay from a rising edge
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            delay_cnt    <= '0;
            edge_pending <= 1'b0;
            sysref_event <= 1'b0;
        end
        else
        begin
            sysref_event <= 1'b0;
            // a disable mid-count drops the edge, so no stale event fires later
            if (!sysref_processor_enable)
                edge_pending <= 1'b0;
            else if (sref_rise)
            begin
                edge_pending <= 1'b1;
                delay_cnt    <= {1'b0, capture_delay_select};
            end
            else if (edge_pending)
            begin
                if (delay_cnt == '0)
                begin
                    edge_pending <= 1'b0;
                    sysref_event <= 1'b1;
                end
                else
                    delay_cnt <= delay_cnt - 1'b1;
            end
        end
    end

    // timestamp only valid when ddc is bypassed; decimated samples keep their lsb
    assign stamp_active = path_options[BIT_TIMESTAMP] && lsb_marker_enable
                        && ddc_bypassed;

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            sample_lsb_out <= 1'b0;
        else if (stamp_active)
            sample_lsb_out <= sref_aligned;
        else
            sample_lsb_out <= lsb_sync[1];
    end

    always_comb
    begin
        case (bus.addr)
            OFS_ENABLE_WINDOW: next_rdata = enable_window;
            OFS_PATH_OPTIONS:  next_rdata = path_options;
            OFS_CLOCK_TUNING:  next_rdata = clock_tuning;
            OFS_POS_LOW:       next_rdata = edge_position_status[7:0];
            OFS_POS_MID:       next_rdata = edge_position_status[15:8];
            OFS_POS_HIGH:      next_rdata = edge_position_status[23:16];
            default:           next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            bus.rdata <= 8'h00;
        else if (bus.rd)
            bus.rdata <= next_rdata;
        else
            bus.rdata <= 8'h00;
    end
endmodule

// ---- hdl/scc_pkg.sv ----
// sysref clock control: register map, field positions, reset values
// shared by the device end, the host end, the link checker and the top bench
package scc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int POS_W  = 24;

    // device register offsets
    localparam logic [7:0] OFS_ENABLE_WINDOW = 8'h29;
    localparam logic [7:0] OFS_PATH_OPTIONS  = 8'h2A;
    localparam logic [7:0] OFS_CLOCK_TUNING  = 8'h2B;
    localparam logic [7:0] OFS_POS_LOW       = 8'h2C;
    localparam logic [7:0] OFS_POS_MID       = 8'h2D;
    localparam logic [7:0] OFS_POS_HIGH      = 8'h2E;

    // sysref_enable_and_window fields
    localparam int BIT_PROC_EN  = 6;
    localparam int BIT_RECV_EN  = 5;
    localparam int BIT_ZOOM     = 4;
    localparam int SEL_MSB      = 3;
    localparam int SEL_W        = 4;
    localparam logic [7:0] MASK_ENABLE_WINDOW = 8'h7F;
    localparam logic [7:0] RST_ENABLE_WINDOW  = 8'h00;

    // sysref_path_options fields
    localparam int BIT_TIMESTAMP = 3;
    localparam int BIT_DEV_DC    = 2;
    localparam int BIT_SYS_DC    = 1;
    localparam int BIT_INVERT    = 0;
    localparam logic [7:0] MASK_PATH_OPTIONS = 8'h0F;
    localparam logic [7:0] RST_PATH_OPTIONS  = 8'h00;

    // clock_path_tuning fields
    localparam int BIT_FB_GAIN    = 4;
    localparam int BIT_NOISE_SUPP = 2;
    localparam int DEL_MSB        = 1;
    localparam int DEL_W          = 2;
    localparam logic [7:0] MASK_CLOCK_TUNING = 8'h17;
    localparam logic [7:0] RST_CLOCK_TUNING  = 8'h11;

    // host command port offsets (register index as byte address)
    localparam logic [7:0] HOFS_ENABLE_WINDOW = 8'h00;
    localparam logic [7:0] HOFS_PATH_OPTIONS  = 8'h01;
    localparam logic [7:0] HOFS_CLOCK_TUNING  = 8'h02;
    localparam logic [7:0] HOFS_POS_LOW       = 8'h03;
    localparam logic [7:0] HOFS_POS_MID       = 8'h04;
    localparam logic [7:0] HOFS_POS_HIGH      = 8'h05;
    localparam logic [7:0] HOFS_STATUS        = 8'h06;
    localparam int HST_BUSY      = 0;
    localparam int HST_ORDER_ERR = 1;
endpackage

// ---- hdl/scc_if.sv ----
// register link between host end and device end of the clock control
// one clock; read data valid the cycle after rd
`timescale 1ns/1ps
interface scc_if;
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport device (input wr, input rd, input addr, input wdata, output rdata);
    modport host   (output wr, output rd, output addr, output wdata, input rdata);
endinterface

// ---- hdl/scc_host.sv ----
// host end: software port registers mirrored to the device link
// assumes the device answers a read one cycle later, never waits
`timescale 1ns/1ps
module scc_host
    import scc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    scc_if.host              link,
    input  wire logic [7:0]  sw_addr,
    input  wire logic [7:0]  sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic      [7:0]  sw_rdata
);
    logic [7:0] dev_addr;
    logic       fwd_wr;
    logic       fwd_rd;
    logic [7:0] masked;
    logic       rd_pend;
    logic       local_rd;
    logic [7:0] local_data;
    logic       order_err;
    logic       recv_seen;

    // map software offsets onto device offsets
    always_comb
    begin
        fwd_wr   = sw_wr;
        fwd_rd   = sw_rd;
        masked   = sw_wdata;
        case (sw_addr)
            HOFS_ENABLE_WINDOW:
            begin
                dev_addr = OFS_ENABLE_WINDOW;
                masked   = sw_wdata & MASK_ENABLE_WINDOW;
                // processor enable is refused when receiver is off both in this write and in the last one
                if (sw_wdata[BIT_PROC_EN] && !recv_seen && !sw_wdata[BIT_RECV_EN])
                    masked[BIT_PROC_EN] = 1'b0;
                // same-write enable would set both at once: refuse processor
                if (sw_wdata[BIT_PROC_EN] && !recv_seen)
                    masked[BIT_PROC_EN] = 1'b0;
            end
            HOFS_PATH_OPTIONS:
            begin
                dev_addr = OFS_PATH_OPTIONS;
                masked   = sw_wdata & MASK_PATH_OPTIONS;
            end
            HOFS_CLOCK_TUNING:
            begin
                dev_addr = OFS_CLOCK_TUNING;
                masked   = sw_wdata & MASK_CLOCK_TUNING;
            end
            HOFS_POS_LOW:  dev_addr = OFS_POS_LOW;
            HOFS_POS_MID:  dev_addr = OFS_POS_MID;
            HOFS_POS_HIGH: dev_addr = OFS_POS_HIGH;
            default:
            begin
                dev_addr = 8'h00;
                fwd_wr   = 1'b0;
                fwd_rd   = 1'b0;
            end
        endcase
    end

    assign link.wr    = fwd_wr;
    assign link.rd    = fwd_rd;
    assign link.addr  = dev_addr;
    assign link.wdata = masked;

    // tracks receiver state so processor enable follows it
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            recv_seen <= 1'b0;
            order_err <= 1'b0;
        end
        else if (sw_wr && sw_addr == HOFS_ENABLE_WINDOW)
        begin
            recv_seen <= sw_wdata[BIT_RECV_EN];
            if (sw_wdata[BIT_PROC_EN] && !recv_seen)
                order_err <= 1'b1;
        end
        else if (sw_wr && sw_addr == HOFS_STATUS && sw_wdata[HST_ORDER_ERR])
            order_err <= 1'b0;
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            rd_pend    <= 1'b0;
            local_rd   <= 1'b0;
            local_data <= 8'h00;
        end
        else
        begin
            rd_pend    <= fwd_rd;
            local_rd   <= sw_rd && sw_addr == HOFS_STATUS;
            local_data <= {6'h00, order_err, 1'b0};
        end
    end

    assign sw_rdata = rd_pend ? link.rdata : (local_rd ? local_data : 8'h00);
endmodule

// ---- verif/scc_monitor.sv ----
// link checker: assertions on the host-to-device register link
// assumes one mclk domain and a synchronous active-high reset
`timescale 1ns/1ps
module scc_monitor
    import scc_pkg::*;
(
    input wire logic       mclk,
    input wire logic       sys_rst,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    logic [7:0] en_sh;
    logic [7:0] opt_sh;
    logic [7:0] tun_sh;

    // shadows follow what actually crossed the link, masked
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            en_sh  <= RST_ENABLE_WINDOW;
            opt_sh <= RST_PATH_OPTIONS;
            tun_sh <= RST_CLOCK_TUNING;
        end
        else if (wr)
        begin
            if (addr == OFS_ENABLE_WINDOW) en_sh <= wdata & MASK_ENABLE_WINDOW;
            if (addr == OFS_PATH_OPTIONS) opt_sh <= wdata & MASK_PATH_OPTIONS;
            if (addr == OFS_CLOCK_TUNING) tun_sh <= wdata & MASK_CLOCK_TUNING;
        end
    end

    a_strobes_exclusive: assert property (!(wr && rd))
        else $error("write and read strobes together");
    a_idle_rdata_zero: assert property (!rd |=> rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    a_unmapped_zero: assert property (rd && !(addr inside {[8'h29:8'h2E]})
        |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_link_addr_mapped: assert property ((wr || rd)
        |-> addr inside {[OFS_ENABLE_WINDOW:OFS_POS_HIGH]})
        else $error("link strobe with unmapped address");
    a_proc_after_recv: assert property (wr && addr == OFS_ENABLE_WINDOW
        && wdata[BIT_PROC_EN] |-> en_sh[BIT_RECV_EN])
        else $error("processor enabled before receiver");
    a_proc_needs_recv: assert property (rd && addr == OFS_ENABLE_WINDOW
        |=> !rdata[BIT_PROC_EN] || rdata[BIT_RECV_EN])
        else $error("processor enable without receiver");
    a_enable_readback: assert property (rd && addr == OFS_ENABLE_WINDOW
        |=> rdata == $past(en_sh))
        else $error("enable register readback wrong");
    a_options_readback: assert property (rd && addr == OFS_PATH_OPTIONS
        |=> rdata == $past(opt_sh))
        else $error("options register readback wrong");
    a_tuning_readback: assert property (rd && addr == OFS_CLOCK_TUNING
        |=> rdata == $past(tun_sh))
        else $error("tuning register readback wrong");

    c_enable_write: cover property (wr && addr == OFS_ENABLE_WINDOW);
    c_status_read: cover property (rd && addr == OFS_POS_LOW);
    c_tuning_read: cover property (rd && addr == OFS_CLOCK_TUNING);
endmodule

// ---- verif/testbench.sv ----
// top bench: host and device ends joined by the link, driven at the port
// assumes one 250 MHz mclk and a synchronous active-high reset
`timescale 1ns/1ps
module testbench
    import scc_pkg::*;
;
    logic       mclk, sys_rst, sref, lsb_en, ddc_byp, lsb_in, sw_wr, sw_rd;
    logic [7:0] sw_addr, sw_wdata, sw_rdata;
    logic       recv, proc, zoom, dev_dc, sys_dc, gain, noise, ev, lsb_out;
    logic [3:0] sel;
    logic [1:0] sdel;
    int         n_errors, comparisons;

    scc_if scc_if_i ();
    scc_device scc_device_i (.mclk(mclk), .sys_rst(sys_rst), .bus(scc_if_i),
        .sysref_in(sref), .lsb_marker_enable(lsb_en), .ddc_bypassed(ddc_byp),
        .sample_lsb_in(lsb_in), .sysref_receiver_enable(recv),
        .sysref_processor_enable(proc), .window_zoom(zoom),
        .capture_delay_select(sel), .device_clock_dc_mode(dev_dc),
        .sysref_dc_mode(sys_dc), .feedback_gain_high(gain),
        .supply_noise_suppress(noise), .sample_clock_delay(sdel),
        .sysref_event(ev), .sample_lsb_out(lsb_out));
    scc_host scc_host_i (.mclk(mclk), .sys_rst(sys_rst), .link(scc_if_i),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata));
    scc_monitor scc_monitor_i (.mclk(mclk), .sys_rst(sys_rst), .wr(scc_if_i.wr),
        .rd(scc_if_i.rd), .addr(scc_if_i.addr), .wdata(scc_if_i.wdata),
        .rdata(scc_if_i.rdata));

    task automatic close_out();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        sw_wr    <= 1'b1;
        sw_addr  <= a;
        sw_wdata <= d;
        @(posedge mclk);
        sw_wr    <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        sw_rd   <= 1'b1;
        sw_addr <= a;
        @(posedge mclk);
        sw_rd   <= 1'b0;
        #1;
        chk(sw_rdata, exp);
    endtask

    // drive sysref to a level, then count event pulses over a span
    task automatic edge_ev(input logic lvl, input int exp);
        int c;
        c = 0;
        @(posedge mclk);
        sref <= lvl;
        repeat (30)
        begin
            @(posedge mclk);
            #1;
            if (ev === 1'b1)
                c++;
        end
        chk(8'(c), 8'(exp));
    endtask

    task automatic mark(input logic e, input logic d, input logic exp);
        @(posedge mclk);
        lsb_en  <= e;
        ddc_byp <= d;
        repeat (5) @(posedge mclk);
        #1;
        chk({7'h00, lsb_out}, {7'h00, exp});
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    initial
    begin
        #20000;
        n_errors++;
        close_out();
    end

    initial
    begin
        {sys_rst, sref, lsb_en, ddc_byp, lsb_in, sw_wr, sw_rd} = 7'h40;
        sw_addr = 8'h00;
        sw_wdata = 8'h00;
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(HOFS_ENABLE_WINDOW, 8'h00);
        rd(HOFS_PATH_OPTIONS, 8'h00);
        rd(HOFS_CLOCK_TUNING, 8'h11);
        chk({3'h0, gain, 1'b0, noise, sdel}, 8'h11);
        for (int i = 3; i < 6; i++) rd(8'(i), 8'h00);
        // processor enable ahead of receiver is refused
        wr(HOFS_ENABLE_WINDOW, 8'h40);
        rd(HOFS_ENABLE_WINDOW, 8'h00);
        rd(HOFS_STATUS, 8'h02);
        wr(HOFS_STATUS, 8'h02);
        rd(HOFS_STATUS, 8'h00);
        wr(HOFS_ENABLE_WINDOW, 8'h20);
        edge_ev(1'b1, 0);
        wr(HOFS_ENABLE_WINDOW, 8'hFF);
        rd(HOFS_ENABLE_WINDOW, 8'h7F);
        chk({1'b0, proc, recv, zoom, sel}, 8'h7F);
        edge_ev(1'b0, 0);
        edge_ev(1'b1, 1);
        // sysref held high far longer than the status depth fills every bit
        for (int i = 3; i < 6; i++) rd(8'(i), 8'hFF);
        wr(HOFS_ENABLE_WINDOW, 8'h60);
        chk({1'b0, proc, recv, zoom, sel}, 8'h60);
        edge_ev(1'b0, 0);
        edge_ev(1'b1, 1);
        wr(HOFS_PATH_OPTIONS, 8'h01);
        edge_ev(1'b0, 1);
        wr(HOFS_PATH_OPTIONS, 8'hFE);
        rd(HOFS_PATH_OPTIONS, 8'h0E);
        chk({6'h00, dev_dc, sys_dc}, 8'h03);
        @(posedge mclk);
        lsb_in <= 1'b1;
        mark(1'b1, 1'b1, 1'b0);
        mark(1'b1, 1'b0, 1'b1);
        mark(1'b0, 1'b1, 1'b1);
        wr(HOFS_CLOCK_TUNING, 8'hFE);
        rd(HOFS_CLOCK_TUNING, 8'h16);
        chk({3'h0, gain, 1'b0, noise, sdel}, 8'h16);
        wr(HOFS_CLOCK_TUNING, 8'h01);
        chk({3'h0, gain, 1'b0, noise, sdel}, 8'h01);
        wr(8'h07, 8'hFF);
        rd(8'h07, 8'h00);
        rd(HOFS_CLOCK_TUNING, 8'h01);
        // second reset in mid-run must restore every written register
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(HOFS_ENABLE_WINDOW, 8'h00);
        chk({1'b0, proc, recv, zoom, sel}, 8'h00);
        rd(HOFS_PATH_OPTIONS, 8'h00);
        rd(HOFS_CLOCK_TUNING, 8'h11);
        close_out();
    end
endmodule
